// ---- core/dsau_core.sv ----
// data-space access unit: x/y buses, alignment, near space and stack checks
`timescale 1ns/1ps
module dsau_core
	import dsau_pkg::*;
#(
	parameter int MEM_WORDS = MEM_WORDS_DEF
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire dsau_req_s req,
	output dsau_rsp_s rsp,
	output logic busy,
	output logic [15:0] stack_pointer_reg,
	output logic [15:0] stack_limit_register
);
	localparam int IDX_W = $clog2(MEM_WORDS);
	localparam logic [16:0] MEM_BYTES = 17'(2 * MEM_WORDS);

	generate
		if (MEM_WORDS < 2 || MEM_WORDS > MAX_WORDS || (1 << IDX_W) != MEM_WORDS
			|| {1'b0, Y_LAST} >= MEM_BYTES)
		begin : g_bad_size
			$error("MEM_WORDS must be a power of two covering the Y block");
		end
	endgenerate

	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = ZERO_WORD;
		for (int i = 0; i < 16; i++)
		begin
			r[i] = v[15-i];
		end
		return r;
	endfunction

	dsau_state_e state;
	logic [15:0] mem [MEM_WORDS];
	logic [7:0] hi_msb;
	logic [PCHI_W-1:0] hi_pc;

	wire in_hi = (state == ST_PC_HI);
	wire op_rd = !in_hi && (req.op == OP_READ);
	wire op_wr = !in_hi && (req.op == OP_WRITE);
	wire op_mac = !in_hi && (req.op == OP_MAC);
	wire op_pc = !in_hi && (req.op == OP_CALL || req.op == OP_EXC);
	wire op_push = in_hi || op_pc || (!in_hi && req.op == OP_PUSH);
	wire op_pop = !in_hi && (req.op == OP_POP);
	wire byte_eff = req.byte_op && (op_rd || op_wr);
	wire is_wr = op_push || op_wr;
	wire x_active = op_rd || op_wr || op_mac || op_push || op_pop;

	// near field is zero-extended, so it can only reach the low 8 Kbytes
	wire [15:0] ea_near = {3'b000, req.near_addr};
	wire [15:0] ea_gen = (req.mode == AM_NEAR) ? ea_near :
		(req.mode == AM_ABS) ? req.abs_addr : req.ptr;
	wire [15:0] sp_dec = stack_pointer_reg - WORD_STEP;
	// one 16-bit byte address for every access, no paging beyond it
	wire [15:0] ea = op_push ? stack_pointer_reg : op_pop ? sp_dec : ea_gen;
	wire [15:0] y_ea = req.y_ptr;

	// boundary comes from constants only, nothing software can move
	wire x_in_y = (ea >= Y_BASE) && (ea <= Y_LAST);
	wire y_in_y = (y_ea >= Y_BASE) && (y_ea <= Y_LAST);
	wire x_hit = {1'b0, ea} < MEM_BYTES;
	wire [IDX_W-1:0] x_idx = ea[IDX_W:1];
	wire [IDX_W-1:0] y_idx = y_ea[IDX_W:1];

	wire mis_x = x_active && !byte_eff && ea[0];
	wire mis_y = op_mac && y_ea[0];
	wire addr_err = mis_x || mis_y;

	wire stk_chk = op_push || op_pop || (req.ptr_is_sp && (op_rd || op_wr)
		&& (req.mode == AM_IND || req.mode == AM_POSTINC));
	// equality is legal, so only an address past the limit overflows
	wire stk_over = stk_chk && is_wr && (ea > stack_limit_register);
	wire stk_under = stk_chk && (ea < SFR_TOP);
	wire stk_err = stk_over || stk_under;

	// the only path into storage; the Y side has no write port at all
	wire wr_go = x_active && is_wr && !mis_x;
	wire [1:0] lane_sel = byte_eff ? (ea[0] ? LANE_HI : LANE_LO) : LANE_BOTH;
	wire [1:0] wr_lane = wr_go ? lane_sel : LANE_NONE;
	wire [15:0] hi_word = {hi_msb, 1'b0, hi_pc};
	wire [15:0] wr_data = in_hi ? hi_word : op_pc ? req.pc[15:0] :
		byte_eff ? {req.wdata[7:0], req.wdata[7:0]} : req.wdata;

	// a MAC X pointer into the Y block reads zero, as does any unimplemented word
	wire x_ok = x_hit && !(op_mac && x_in_y);
	wire [15:0] x_word = x_ok ? mem[x_idx] : ZERO_WORD;
	// Y path is word only and ignores bit 0 for data selection
	wire [15:0] y_word = (op_mac && y_in_y) ? mem[y_idx] : ZERO_WORD;
	wire [7:0] x_byte = ea[0] ? x_word[15:8] : x_word[7:0];
	wire [15:0] x_out = byte_eff ? {ZERO_BYTE, x_byte} : x_word;
	wire [15:0] wb_out = byte_eff ? {req.dest_old[15:8], x_byte} : x_word;

	wire [15:0] step = byte_eff ? BYTE_STEP : WORD_STEP;
	wire [15:0] inc_ptr = req.ptr + step;
	// reverse-carry add; reads in this mode fall back to a plain increment
	wire [15:0] rev_ptr = rev16(16'(rev16(req.ptr) + rev16(req.modifier)));
	wire [15:0] next_ptr = (req.mode == AM_POSTINC) ? inc_ptr :
		(req.mode == AM_BITREV) ? (op_wr ? rev_ptr : inc_ptr) : req.ptr;

	wire [15:0] next_sp = (op_push && !mis_x) ? stack_pointer_reg + WORD_STEP :
		(op_pop && !mis_x) ? sp_dec :
		(!in_hi && req.op == OP_SP_WR) ? (req.wdata & ALIGN_MASK) :
		stack_pointer_reg;

	dsau_rsp_s next_rsp;
	always_comb
	begin
		next_rsp.valid = x_active;
		next_rsp.x_rdata = x_out;
		next_rsp.y_rdata = y_word;
		next_rsp.reg_wb = wb_out;
		next_rsp.ptr_next = next_ptr;
		next_rsp.wr_lane = wr_lane;
		next_rsp.addr_err_trap = addr_err;
		next_rsp.stack_err_trap = stk_err;
	end

	generate
		for (genvar w = 0; w < MEM_WORDS; w++)
		begin : g_word
			always_ff @(posedge mclk)
			begin
				if (clk_en && x_idx == IDX_W'(w) && x_hit)
				begin
					if (wr_lane[0])
						mem[w][7:0] <= wr_data[7:0];
					if (wr_lane[1])
						mem[w][15:8] <= wr_data[15:8];
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state <= ST_IDLE;
			busy <= 1'b0;
			hi_msb <= ZERO_BYTE;
			hi_pc <= '0;
		end
		else if (clk_en)
		begin
			state <= op_pc ? ST_PC_HI : ST_IDLE;
			busy <= op_pc;
			if (op_pc)
			begin
				hi_msb <= (req.op == OP_EXC) ? req.status_low_byte : ZERO_BYTE;
				hi_pc <= req.pc[PC_W-1:16];
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rsp <= '0;
			stack_pointer_reg <= SP_RESET;
		end
		else if (clk_en)
		begin
			rsp <= next_rsp;
			stack_pointer_reg <= next_sp;
		end
	end

	// left out of reset on purpose; bit 0 is masked on every load
	always_ff @(posedge mclk)
	begin
		if (clk_en && !in_hi && req.op == OP_LIM_WR)
			stack_limit_register <= req.wdata & ALIGN_MASK;
	end

	default clocking dcb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	property p_mis_write;
		clk_en && mis_x && is_wr |=> rsp.addr_err_trap && rsp.wr_lane == LANE_NONE;
	endproperty
	a_mis_write: assert property (p_mis_write) else $error("misaligned write not suppressed");

	property p_mis_read;
		clk_en && mis_x && op_rd |=> rsp.addr_err_trap && rsp.valid;
	endproperty
	a_mis_read: assert property (p_mis_read) else $error("misaligned read did not trap");

	property p_byte_lane;
		clk_en && op_wr && req.byte_op |=> $onehot(rsp.wr_lane) && rsp.wr_lane[1] == $past(ea[0]);
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("byte write hit wrong lane");

	property p_mac_cross;
		clk_en && op_mac && (x_in_y || !y_in_y) |=>
			(rsp.x_rdata == ZERO_WORD || !$past(x_in_y)) && (rsp.y_rdata == ZERO_WORD || $past(y_in_y));
	endproperty
	a_mac_cross: assert property (p_mac_cross) else $error("cross-space MAC read not zero");

	property p_byte_read;
		clk_en && op_rd && req.byte_op |=> rsp.x_rdata[15:8] == ZERO_BYTE
			&& rsp.reg_wb[15:8] == $past(req.dest_old[15:8]) && rsp.reg_wb[7:0] == rsp.x_rdata[7:0];
	endproperty
	a_byte_read: assert property (p_byte_read) else $error("byte read merge wrong");

	property p_postinc;
		clk_en && (op_rd || op_wr) && req.mode == AM_POSTINC |=>
			rsp.ptr_next == 16'($past(req.ptr) + ($past(req.byte_op) ? 16'h0001 : 16'h0002));
	endproperty
	a_postinc: assert property (p_postinc) else $error("post-increment step wrong");

	property p_at_limit;
		clk_en && op_push && ea == stack_limit_register && ea >= SFR_TOP |=> !rsp.stack_err_trap;
	endproperty
	a_at_limit: assert property (p_at_limit) else $error("push at limit trapped");

	property p_past_limit;
		clk_en && op_push && ea > stack_limit_register |=> rsp.stack_err_trap;
	endproperty
	a_past_limit: assert property (p_past_limit) else $error("push past limit missed");

	property p_underflow;
		clk_en && stk_chk && ea < SFR_TOP |=> rsp.stack_err_trap;
	endproperty
	a_underflow: assert property (p_underflow) else $error("stack underflow missed");

	property p_sp_step;
		clk_en && !mis_x && (op_push || op_pop) |=>
			stack_pointer_reg == 16'($past(stack_pointer_reg) + ($past(op_push) ? 16'h0002 : 16'hFFFE));
	endproperty
	a_sp_step: assert property (p_sp_step) else $error("stack pointer step wrong");

	property p_pc_upper;
		clk_en && op_pc |=> in_hi && busy && hi_msb == ($past(req.op) == OP_EXC ? $past(req.status_low_byte) : 8'h00);
	endproperty
	a_pc_upper: assert property (p_pc_upper) else $error("pushed upper byte wrong");

	property p_lim_bit0;
		clk_en && !in_hi && req.op == OP_LIM_WR |=> stack_limit_register[0] == 1'b0;
	endproperty
	a_lim_bit0: assert property (p_lim_bit0) else $error("stack limit bit 0 set");

	property p_mac_no_write;
		clk_en && op_mac |=> rsp.wr_lane == LANE_NONE;
	endproperty
	a_mac_no_write: assert property (p_mac_no_write) else $error("dual fetch wrote storage");

	property p_read_no_write;
		clk_en && (op_rd || op_pop) |=> rsp.wr_lane == LANE_NONE;
	endproperty
	a_read_no_write: assert property (p_read_no_write) else $error("read strobed a lane");

	property p_bitrev_rd;
		clk_en && op_rd && req.mode == AM_BITREV |=>
			rsp.ptr_next == 16'($past(req.ptr) + ($past(req.byte_op) ? 16'h0001 : 16'h0002));
	endproperty
	a_bitrev_rd: assert property (p_bitrev_rd) else $error("bit-reverse applied to read");

	property p_y_word;
		clk_en && op_mac && y_in_y |=> rsp.y_rdata == $past(mem[y_idx]);
	endproperty
	a_y_word: assert property (p_y_word) else $error("Y fetch not a whole word");

	property p_near_ea;
		clk_en && x_active && !op_push && !op_pop && req.mode == AM_NEAR |-> ea[15:13] == 3'b000;
	endproperty
	a_near_ea: assert property (p_near_ea) else $error("near address left low 8 Kbytes");

	property p_sep_traps;
		clk_en && !stk_chk |=> !rsp.stack_err_trap;
	endproperty
	a_sep_traps: assert property (p_sep_traps) else $error("stack trap without stack address");

	property p_word_lane;
		clk_en && op_wr && !req.byte_op && !ea[0] |=> rsp.wr_lane == LANE_BOTH;
	endproperty
	a_word_lane: assert property (p_word_lane) else $error("word write missed a lane");
endmodule

// ---- core/dsau_pkg.sv ----
// shared constants and types for the data-space access unit
package dsau_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int NEAR_W = 13;
	localparam int PC_W = 23;
	localparam int PCHI_W = 7;
	localparam int MEM_WORDS_DEF = 2048;
	localparam int MAX_WORDS = 32768;
	localparam logic [15:0] SFR_TOP = 16'h0800;
	localparam logic [15:0] SP_RESET = 16'h0800;
	localparam logic [15:0] Y_BASE = 16'h0C00;
	localparam logic [15:0] Y_LAST = 16'h0FFF;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [15:0] BYTE_STEP = 16'h0001;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] ALIGN_MASK = 16'hFFFE;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [1:0] LANE_NONE = 2'h0;
	localparam logic [1:0] LANE_LO = 2'h1;
	localparam logic [1:0] LANE_HI = 2'h2;
	localparam logic [1:0] LANE_BOTH = 2'h3;

	typedef enum logic [3:0] {
		OP_NONE, OP_READ, OP_WRITE, OP_MAC, OP_PUSH, OP_POP,
		OP_CALL, OP_EXC, OP_SP_WR, OP_LIM_WR
	} dsau_op_e;

	typedef enum logic [2:0] {AM_IND, AM_POSTINC, AM_BITREV, AM_NEAR, AM_ABS} dsau_mode_e;

	typedef enum logic {ST_IDLE, ST_PC_HI} dsau_state_e;

	typedef struct packed {
		dsau_op_e op;
		dsau_mode_e mode;
		logic byte_op;
		logic ptr_is_sp;
		logic [15:0] ptr;
		logic [15:0] y_ptr;
		logic [NEAR_W-1:0] near_addr;
		logic [15:0] abs_addr;
		logic [15:0] modifier;
		logic [15:0] wdata;
		logic [15:0] dest_old;
		logic [PC_W-1:0] pc;
		logic [7:0] status_low_byte;
	} dsau_req_s;

	typedef struct packed {
		logic valid;
		logic [15:0] x_rdata;
		logic [15:0] y_rdata;
		logic [15:0] reg_wb;
		logic [15:0] ptr_next;
		logic [1:0] wr_lane;
		logic addr_err_trap;
		logic stack_err_trap;
	} dsau_rsp_s;
endpackage

// ---- bench/dsau_exec_model.sv ----
// pipeline-side request source that feeds the access unit
`timescale 1ns/1ps
module dsau_exec_model
	import dsau_pkg::*;
(
	input wire logic mclk,
	input wire logic busy,
	output dsau_req_s req
);
	logic after_lim;
	initial
	begin
		req = '0;
		after_lim = 1'b0;
	end
	// a request is held back through up to 7 busy cycles, so nothing is lost; an eighth busy cycle ends the run
	task automatic issue(input dsau_req_s r);
		int n;
		n = 0;
		@(negedge mclk);
		if (after_lim)
		begin
			req.op = OP_NONE;
			@(negedge mclk);
		end
		while (busy !== 1'b0 && n < 8)
		begin
			n++;
			@(negedge mclk);
		end
		if (n == 8)
			tb_top.stall_out();
		req = r;
		after_lim = (r.op == OP_LIM_WR);
	endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench: driver queues expectations, monitor compares
`timescale 1ns/1ps
module tb_top;
	import dsau_pkg::*;
	logic mclk;
	logic sys_rst;
	logic clk_en;
	logic busy;
	logic [15:0] sp;
	logic [15:0] lim;
	logic [15:0] d;
	logic [15:0] v;
	logic [15:0] dd [4];
	logic [22:0] pc;
	logic [7:0] status_low_byte;
	dsau_req_s req;
	dsau_req_s r;
	dsau_rsp_s rsp;
	dsau_rsp_s exq [$];
	dsau_rsp_s mkq [$];
	int miscompares;
	int total_checks;
	dsau_core #(.MEM_WORDS(2048)) dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
		.req(req), .rsp(rsp), .busy(busy), .stack_pointer_reg(sp), .stack_limit_register(lim));
	dsau_exec_model pm (.mclk(mclk), .busy(busy), .req(req));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(input logic [68:0] seen, input logic [68:0] exp, input logic [68:0] m);
		total_checks++;
		if ((seen & m) !== (exp & m))
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen & m, exp & m);
		end
	endtask
	task automatic close_out();
		$display("checks %0d, miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic stall_out();
		miscompares++;
		close_out();
	endtask
	function automatic dsau_req_s rq(dsau_op_e o, dsau_mode_e md, logic b, logic [15:0] p,
		logic [15:0] w);
		return '{op: o, mode: md, byte_op: b, ptr: p, wdata: w, default: '0};
	endfunction
	function automatic dsau_rsp_s xp(logic [15:0] x, logic [15:0] wb, logic [15:0] pn,
		logic [1:0] ln, logic ae, logic se);
		return '{1'b1, x, ZERO_WORD, wb, pn, ln, ae, se};
	endfunction
	// masks keep each expectation to the fields a scenario can predict
	function automatic dsau_rsp_s mk(logic rd, logic wb, logic pn, logic ln);
		return '{1'b1, {16{rd}}, {16{rd}}, {16{wb}}, {16{pn}}, {2{ln}}, 1'b1, 1'b1};
	endfunction
	task automatic go(input dsau_req_s q, input dsau_rsp_s x, input dsau_rsp_s k);
		exq.push_back(x);
		mkq.push_back(k);
		pm.issue(q);
	endtask
	task automatic idle();
		pm.issue(rq(OP_NONE, AM_IND, 1'b0, ZERO_WORD, ZERO_WORD));
	endtask
	initial
	begin
		forever
		begin
			@(posedge mclk);
			#1;
			if (rsp.valid === 1'b1)
			begin
				if (exq.size() == 0)
					check(rsp, '0, '1);
				else
					check(rsp, exq.pop_front(), mkq.pop_front());
			end
		end
	end
	initial
	begin
		miscompares = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		void'($urandom(32'hF9EE));
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'b0;
		check(sp, SP_RESET, '1);
		for (int i = 0; i < 4; i++)
		begin
			dd[i] = 16'($urandom);
			d = 16'h0100 + 16'(2 * i);
			go(rq(OP_WRITE, AM_POSTINC, 1'b0, d, dd[i]), xp(0, 0, d + WORD_STEP, LANE_BOTH, 0, 0),
				mk(0, 0, 1, 1));
			go(rq(OP_READ, AM_IND, 1'b0, d, 0), xp(dd[i], dd[i], 0, LANE_NONE, 0, 0),
				mk(1, 1, 0, 1));
		end
		$display("word access test done");
		d = 16'($urandom);
		v = 16'($urandom);
		go(rq(OP_WRITE, AM_IND, 1'b0, 16'h0200, d), xp(0, 0, 0, LANE_BOTH, 0, 0), mk(0, 0, 0, 1));
		go(rq(OP_WRITE, AM_POSTINC, 1'b1, 16'h0201, v), xp(0, 0, 16'h0202, LANE_HI, 0, 0),
			mk(0, 0, 1, 1));
		r = rq(OP_READ, AM_IND, 1'b1, 16'h0200, 0);
		r.dest_old = v;
		go(r, xp({ZERO_BYTE, d[7:0]}, {v[15:8], d[7:0]}, 0, 0, 0, 0), mk(1, 1, 0, 0));
		r.ptr = 16'h0201;
		go(r, xp({ZERO_BYTE, v[7:0]}, {v[15:8], v[7:0]}, 0, 0, 0, 0), mk(1, 1, 0, 0));
		// the suppressed write leaves the word as the byte tests built it
		go(rq(OP_WRITE, AM_IND, 1'b0, 16'h0201, v), xp(0, 0, 0, LANE_NONE, 1, 0), mk(0, 0, 0, 1));
		go(rq(OP_READ, AM_IND, 1'b0, 16'h0201, 0), xp({v[7:0], d[7:0]}, 0, 0, 0, 1, 0),
			mk(1, 0, 0, 0));
		go(rq(OP_READ, AM_IND, 1'b0, 16'h2000, 0), xp(0, 0, 0, 0, 0, 0), mk(1, 0, 0, 0));
		r = rq(OP_READ, AM_NEAR, 1'b0, 16'hFFFE, 0);
		r.near_addr = 13'h0102;
		go(r, xp(dd[1], 0, 0, 0, 0, 0), mk(1, 0, 0, 0));
		r.mode = AM_ABS;
		r.abs_addr = 16'h0104;
		go(r, xp(dd[2], 0, 0, 0, 0, 0), mk(1, 0, 0, 0));
		$display("byte, alignment and direct test done");
		go(rq(OP_WRITE, AM_IND, 1'b0, Y_BASE, v), xp(0, 0, 0, LANE_BOTH, 0, 0), mk(0, 0, 0, 1));
		r = rq(OP_MAC, AM_IND, 1'b0, 16'h0106, 0);
		r.y_ptr = Y_BASE;
		go(r, '{1'b1, dd[3], v, 16'h0, 16'h0, 2'h0, 1'b0, 1'b0}, mk(1, 0, 0, 1));
		r.ptr = Y_BASE;
		r.y_ptr = 16'h0106;
		go(r, xp(0, 0, 0, 0, 0, 0), mk(1, 0, 0, 1));
		// reverse-carry add of 0x0008 to 0x0108 carries down into bit 2
		r = rq(OP_WRITE, AM_BITREV, 1'b0, 16'h0108, v);
		r.modifier = 16'h0008;
		go(r, xp(0, 0, 16'h0104, LANE_BOTH, 0, 0), mk(0, 0, 1, 1));
		r.op = OP_READ;
		go(r, xp(v, v, 16'h010A, LANE_NONE, 0, 0), mk(1, 1, 1, 1));
		$display("dual fetch test done");
		pm.issue(rq(OP_LIM_WR, AM_IND, 1'b0, 0, 16'h0901));
		pm.issue(rq(OP_SP_WR, AM_IND, 1'b0, 0, 16'h0900));
		go(rq(OP_PUSH, AM_IND, 1'b0, 0, d), xp(0, 0, 0, 0, 0, 0), mk(0, 0, 0, 0));
		go(rq(OP_PUSH, AM_IND, 1'b0, 0, v), xp(0, 0, 0, 0, 0, 1), mk(0, 0, 0, 0));
		idle();
		check(lim, 16'h0900, '1);
		check(sp, 16'h0904, '1);
		go(rq(OP_POP, AM_IND, 1'b0, 0, 0), xp(v, 0, 0, 0, 0, 0), mk(1, 0, 0, 0));
		pm.issue(rq(OP_SP_WR, AM_IND, 1'b0, 0, SFR_TOP));
		go(rq(OP_POP, AM_IND, 1'b0, 0, 0), xp(0, 0, 0, 0, 0, 1), mk(0, 0, 0, 0));
		idle();
		// freeze only once the last response has been replaced by an idle one
		@(negedge mclk);
		clk_en = 1'b0;
		pm.issue(rq(OP_SP_WR, AM_IND, 1'b0, 0, Y_BASE));
		repeat (2) @(negedge mclk);
		check(sp, 16'h07FE, '1);
		clk_en = 1'b1;
		$display("stack limit test done");
		for (int e = 0; e < 2; e++)
		begin
			pc = 23'($urandom);
			status_low_byte = 8'($urandom);
			pm.issue(rq(OP_SP_WR, AM_IND, 1'b0, 0, SFR_TOP));
			r = rq(e ? OP_EXC : OP_CALL, AM_IND, 1'b0, 0, 0);
			r.pc = pc;
			r.status_low_byte = status_low_byte;
			go(r, xp(0, 0, 0, 0, 0, 0), mk(0, 0, 0, 0));
			exq.push_back(xp(0, 0, 0, 0, 0, 0));
			mkq.push_back(mk(0, 0, 0, 0));
			go(rq(OP_POP, AM_IND, 1'b0, 0, 0), xp({e ? status_low_byte : ZERO_BYTE, 1'b0, pc[22:16]}, 0, 0, 0, 0, 0),
				mk(1, 0, 0, 0));
			go(rq(OP_POP, AM_IND, 1'b0, 0, 0), xp(pc[15:0], 0, 0, 0, 0, 0), mk(1, 0, 0, 0));
		end
		$display("call and exception push test done");
		idle();
		for (int t = 0; t < 20 && exq.size() > 0; t++)
			@(posedge mclk);
		if (exq.size() > 0)
			miscompares++;
		close_out();
	end
endmodule
